//--- logic/cio_pkg.sv
/*
 * Constants for the configurable I/O port driver: register offsets,
 * field positions, reset values, driver mode codes and timing counts.
 * Assumes a 32-bit AHB-Lite register bus with one word per register.
 */
`default_nettype none
package cio_pkg;
	////////////////////////////////////////////////////////////////////
	localparam int unsigned P0_W = 8;
	localparam int unsigned P1_W = 8;
	localparam int unsigned P2_W = 2;
	localparam int unsigned PIN_N = P0_W + P1_W + P2_W;
	localparam int unsigned OFS_W = 8;
	////////////////////////////////////////////////////////////////////
	localparam logic [OFS_W-1:0] OFS_P0_LATCH = 8'h00;
	localparam logic [OFS_W-1:0] OFS_P1_LATCH = 8'h04;
	localparam logic [OFS_W-1:0] OFS_P2_LATCH = 8'h08;
	localparam logic [OFS_W-1:0] OFS_P0_MODE_A = 8'h0C;
	localparam logic [OFS_W-1:0] OFS_P0_MODE_B = 8'h10;
	localparam logic [OFS_W-1:0] OFS_P1_MODE_A = 8'h14;
	localparam logic [OFS_W-1:0] OFS_P1_MODE_B = 8'h18;
	localparam logic [OFS_W-1:0] OFS_P2_MODE_A = 8'h1C;
	localparam logic [OFS_W-1:0] OFS_P2_MODE_B = 8'h20;
	localparam logic [OFS_W-1:0] OFS_P0_PINS = 8'h24;
	localparam logic [OFS_W-1:0] OFS_P1_PINS = 8'h28;
	localparam logic [OFS_W-1:0] OFS_P2_PINS = 8'h2C;
	////////////////////////////////////////////////////////////////////
	localparam int unsigned P2A_SCHMITT2_BIT = 7;
	localparam int unsigned P2A_SCHMITT1_BIT = 6;
	localparam int unsigned P2A_SCHMITT0_BIT = 5;
	localparam int unsigned P2A_CLKOUT_BIT = 4;
	localparam int unsigned P2A_T1_TOGGLE_BIT = 3;
	localparam int unsigned P2A_T0_TOGGLE_BIT = 2;
	localparam int unsigned P1_OD_BIT2 = 2;
	localparam int unsigned P1_OD_BIT3 = 3;
	localparam int unsigned P1_RST_BIT = 5;
	localparam logic [7:0] P1_FIXED_SCHMITT = 8'h2C;
	////////////////////////////////////////////////////////////////////
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] LATCH_HI = 8'hFF;
	localparam logic [7:0] LATCH_LO = 8'h00;
	localparam logic [1:0] STRONG_PU_CYC = 2'h2;
	typedef enum logic [1:0] {
		CIO_QUASI = 2'b00,
		CIO_PUSH  = 2'b01,
		CIO_INPUT = 2'b10,
		CIO_OPEN  = 2'b11
	} cio_mode_e;
endpackage
`default_nettype wire

//--- logic/cio_in_sync.sv
/*
 * Three-stage pin input synchroniser with agreement filter.
 * Assumes inputs are asynchronous to hclk.
 */
`timescale 1ns/10ps
`default_nettype none
module cio_in_sync #(
	parameter int unsigned W = 8
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] level_reg;
	logic [W-1:0] agree;

	assign agree = ~(s2_reg ^ s3_reg);
	assign level = level_reg;

	// Only s2 reads s1, keeping metastability out of the filter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_reg    <= '0;
			s2_reg    <= '0;
			s3_reg    <= '0;
			level_reg <= '0;
		end else begin
			s1_reg    <= pin_in;
			s2_reg    <= s1_reg;
			s3_reg    <= s2_reg;
			level_reg <= (s3_reg & agree) | (level_reg & ~agree);
		end
	end
endmodule // cio_in_sync
`default_nettype wire

//--- logic/cio_pin_cell.sv
/*
 * Driver control of one port pin: pull-up and pull-down enables.
 * Assumes latch and pin level are registered on hclk.
 */
`timescale 1ns/10ps
`default_nettype none
module cio_pin_cell
	import cio_pkg::*;
(
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [1:0] mode,
	input  wire logic       latch,
	input  wire logic       pin_level,
	input  wire logic       fixed_od,
	input  wire logic       off,
	output logic            vweak_pu_en,
	output logic            weak_pu_en,
	output logic            strong_pu_en,
	output logic            pull_dn_en
);
	cio_mode_e  eff_mode;
	logic       prev_reg;
	logic [1:0] burst_reg;
	logic       rise;

	assign eff_mode = fixed_od ? CIO_OPEN : cio_mode_e'(mode);
	assign rise = latch & ~prev_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_reg <= 1'b1;
		end else begin
			prev_reg <= latch;
		end
	end

	// Edge cycle plus remaining count gives exactly two clocks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			burst_reg <= 2'h0;
		end else if (rise && eff_mode == CIO_QUASI) begin
			burst_reg <= STRONG_PU_CYC - 2'h1;
		end else if (burst_reg != 2'h0) begin
			burst_reg <= burst_reg - 2'h1;
		end
	end

	always_comb begin
		vweak_pu_en  = 1'b0;
		weak_pu_en   = 1'b0;
		strong_pu_en = 1'b0;
		pull_dn_en   = 1'b0;
		if (!off) begin
			case (eff_mode)
				CIO_QUASI: begin
					vweak_pu_en  = latch;
					weak_pu_en   = latch & pin_level;
					strong_pu_en = latch & (rise | burst_reg != 2'h0);
					pull_dn_en   = ~latch;
				end
				CIO_PUSH: begin
					strong_pu_en = latch;
					pull_dn_en   = ~latch;
				end
				CIO_OPEN: begin
					pull_dn_en = ~latch;
				end
				CIO_INPUT: begin
					pull_dn_en = 1'b0;
				end
				default: begin
					pull_dn_en = 1'b0;
				end
			endcase
		end
	end
endmodule // cio_pin_cell
`default_nettype wire

//--- logic/cio_port.sv
/*
 * Configurable I/O port driver for three ports with AHB-Lite registers.
 * Assumes static user configuration inputs and external pad drivers
 * that act on the pull-up and pull-down enables.
 */
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module cio_port
	import cio_pkg::*;
(
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic      [31:0]          hrdata,
	input  wire logic                 reset_level_high_sel,
	input  wire logic                 internal_reset_sel,
	input  wire logic                 crystal_osc_sel,
	input  wire logic [cio_pkg::P0_W-1:0] port0_pin_in,
	input  wire logic [cio_pkg::P1_W-1:0] port1_pin_in,
	input  wire logic [cio_pkg::P2_W-1:0] port2_pin_in,
	output logic      [cio_pkg::PIN_N-1:0] pin_vweak_pu_en,
	output logic      [cio_pkg::PIN_N-1:0] pin_weak_pu_en,
	output logic      [cio_pkg::PIN_N-1:0] pin_strong_pu_en,
	output logic      [cio_pkg::PIN_N-1:0] pin_pull_dn_en,
	output logic      [cio_pkg::PIN_N-1:0] pin_input_en,
	output logic      [cio_pkg::P0_W-1:0] port0_schmitt_en,
	output logic      [cio_pkg::P1_W-1:0] port1_schmitt_en,
	output logic      [cio_pkg::P2_W-1:0] port2_schmitt_en,
	output logic                      timer_zero_toggle_en,
	output logic                      timer_one_toggle_en,
	output logic                      clock_output_en
);
	import cio_pkg::*;

	////////////////////////////////////////////////////////////////////
	logic [P0_W-1:0]  p0_latch_reg;
	logic [P1_W-1:0]  p1_latch_reg;
	logic [P2_W-1:0]  p2_latch_reg;
	logic [7:0]       port_mode_reg_a0;
	logic [7:0]       port_mode_reg_b0;
	logic [7:0]       port_mode_reg_a1;
	logic [7:0]       port_mode_reg_b1;
	logic [7:0]       port2_mode_reg_a;
	logic [P2_W-1:0]  port2_mode_reg_b;
	logic             cfg_done_reg;
	logic             int_rst_reg;
	logic             xtal_reg;
	logic             wr_pend_reg;
	logic [OFS_W-1:0] wr_ofs_reg;
	logic [31:0]      hrdata_reg;
	logic [31:0]      rd_next;
	logic             addr_ok;
	logic [OFS_W-1:0] a_ofs;
	logic [P0_W-1:0]  p0_lvl;
	logic [P1_W-1:0]  p1_lvl;
	logic [P2_W-1:0]  p2_lvl;
	logic [P1_W-1:0]  p1_read;
	logic [P2_W-1:0]  p2_read;
	logic [PIN_N-1:0] all_mode_a;
	logic [PIN_N-1:0] all_mode_b;
	logic [PIN_N-1:0] all_latch;
	logic [PIN_N-1:0] all_lvl;
	logic [PIN_N-1:0] all_od;
	logic [PIN_N-1:0] all_off;

	////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;
	assign addr_ok   = hsel & htrans[1] & hready;
	assign a_ofs     = haddr[OFS_W-1:0];

	// A write lands at the end of its data phase, when hwdata stands
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
		end else begin
			wr_pend_reg <= addr_ok & hwrite;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ofs_reg <= '0;
		end else if (addr_ok) begin
			wr_ofs_reg <= a_ofs;
		end
	end

	// Read data is fixed at the address phase; unmapped offsets read zero
	always_comb begin
		rd_next = 32'h0000_0000;
		case (a_ofs)
			OFS_P0_LATCH:  rd_next[P0_W-1:0] = p0_latch_reg;
			OFS_P1_LATCH:  rd_next[P1_W-1:0] = p1_latch_reg;
			OFS_P2_LATCH:  rd_next[P2_W-1:0] = p2_latch_reg;
			OFS_P0_MODE_A: rd_next[7:0] = port_mode_reg_a0;
			OFS_P0_MODE_B: rd_next[7:0] = port_mode_reg_b0;
			OFS_P1_MODE_A: rd_next[7:0] = port_mode_reg_a1;
			OFS_P1_MODE_B: rd_next[7:0] = port_mode_reg_b1;
			OFS_P2_MODE_A: rd_next[7:0] = port2_mode_reg_a;
			OFS_P2_MODE_B: rd_next[P2_W-1:0] = port2_mode_reg_b;
			OFS_P0_PINS:   rd_next[P0_W-1:0] = p0_lvl;
			OFS_P1_PINS:   rd_next[P1_W-1:0] = p1_read;
			OFS_P2_PINS:   rd_next[P2_W-1:0] = p2_read;
			default:       rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			hrdata_reg <= rd_next;
		end
	end

	////////////////////////////////////////////////////////////////////
	// User configuration is caught once, the first edge after release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_done_reg <= 1'b0;
		end else begin
			cfg_done_reg <= 1'b1;
		end
	end

	// Sampling once keeps a glitching option input from moving pins later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_rst_reg <= 1'b0;
		end else if (!cfg_done_reg) begin
			int_rst_reg <= internal_reset_sel;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xtal_reg <= 1'b0;
		end else if (!cfg_done_reg) begin
			xtal_reg <= crystal_osc_sel;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Latches start high, then settle to the configured reset level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p0_latch_reg <= LATCH_HI;
		end else if (!cfg_done_reg) begin
			p0_latch_reg <= reset_level_high_sel ? LATCH_HI : LATCH_LO;
		end else if (wr_pend_reg && wr_ofs_reg == OFS_P0_LATCH) begin
			p0_latch_reg <= hwdata[P0_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p1_latch_reg <= LATCH_HI;
		end else if (!cfg_done_reg) begin
			p1_latch_reg <= reset_level_high_sel ? LATCH_HI : LATCH_LO;
		end else if (wr_pend_reg && wr_ofs_reg == OFS_P1_LATCH) begin
			p1_latch_reg <= hwdata[P1_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p2_latch_reg <= LATCH_HI[P2_W-1:0];
		end else if (!cfg_done_reg) begin
			p2_latch_reg <= reset_level_high_sel ? LATCH_HI[P2_W-1:0]
				: LATCH_LO[P2_W-1:0];
		end else if (wr_pend_reg && wr_ofs_reg == OFS_P2_LATCH) begin
			p2_latch_reg <= hwdata[P2_W-1:0];
		end
	end

	// Modes reset to quasi, so pins reset high are never strongly driven
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_mode_reg_a0 <= MODE_RST;
		end else if (wr_pend_reg && wr_ofs_reg == OFS_P0_MODE_A) begin
			port_mode_reg_a0 <= hwdata[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_mode_reg_b0 <= MODE_RST;
		end else if (wr_pend_reg && wr_ofs_reg == OFS_P0_MODE_B) begin
			port_mode_reg_b0 <= hwdata[7:0];
		end
	end

	// Mode bits of the fixed pins are stored but their cells ignore them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_mode_reg_a1 <= MODE_RST;
		end else if (wr_pend_reg && wr_ofs_reg == OFS_P1_MODE_A) begin
			port_mode_reg_a1 <= hwdata[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_mode_reg_b1 <= MODE_RST;
		end else if (wr_pend_reg && wr_ofs_reg == OFS_P1_MODE_B) begin
			port_mode_reg_b1 <= hwdata[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port2_mode_reg_a <= MODE_RST;
		end else if (wr_pend_reg && wr_ofs_reg == OFS_P2_MODE_A) begin
			port2_mode_reg_a <= hwdata[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port2_mode_reg_b <= MODE_RST[P2_W-1:0];
		end else if (wr_pend_reg && wr_ofs_reg == OFS_P2_MODE_B) begin
			port2_mode_reg_b <= hwdata[P2_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin inputs
	cio_in_sync #(
		.W(P0_W)
	) u_sync0 (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin_in  (port0_pin_in),
		.level   (p0_lvl)
	);

	cio_in_sync #(
		.W(P1_W)
	) u_sync1 (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin_in  (port1_pin_in),
		.level   (p1_lvl)
	);

	cio_in_sync #(
		.W(P2_W)
	) u_sync2 (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin_in  (port2_pin_in),
		.level   (p2_lvl)
	);

	// Unused input buffers read low rather than floating values
	always_comb begin
		p1_read = p1_lvl;
		p1_read[P1_RST_BIT] = p1_lvl[P1_RST_BIT] & int_rst_reg;
		p2_read = p2_lvl & {P2_W{~xtal_reg}};
	end

	////////////////////////////////////////////////////////////////////
	// Per-pin drivers, flattened port 0, then port 1, then port 2
	assign all_mode_a = {port2_mode_reg_a[P2_W-1:0], port_mode_reg_a1, port_mode_reg_a0};
	assign all_mode_b = {port2_mode_reg_b, port_mode_reg_b1, port_mode_reg_b0};
	assign all_latch  = {p2_latch_reg, p1_latch_reg, p0_latch_reg};
	assign all_lvl    = {p2_lvl, p1_lvl, p0_lvl};

	// Fixed open-drain pins ignore their mode bits
	always_comb begin
		all_od = '0;
		all_od[P0_W + P1_OD_BIT2] = 1'b1;
		all_od[P0_W + P1_OD_BIT3] = 1'b1;
	end

	// Oscillator pins are cut off both ways while a crystal runs
	always_comb begin
		all_off = '0;
		all_off[P0_W + P1_RST_BIT] = 1'b1;
		all_off[PIN_N-1 -: P2_W] = {P2_W{xtal_reg}};
	end

	always_comb begin
		pin_input_en = ~all_off;
		pin_input_en[P0_W + P1_RST_BIT] = int_rst_reg;
	end

	// One cell per pin; cells share no state, so pins never interact
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_pin
			cio_pin_cell u_cell (
				.hclk         (hclk),
				.hresetn      (hresetn),
				.mode         ({all_mode_a[gi], all_mode_b[gi]}),
				.latch        (all_latch[gi]),
				.pin_level    (all_lvl[gi]),
				.fixed_od     (all_od[gi]),
				.off          (all_off[gi]),
				.vweak_pu_en  (pin_vweak_pu_en[gi]),
				.weak_pu_en   (pin_weak_pu_en[gi]),
				.strong_pu_en (pin_strong_pu_en[gi]),
				.pull_dn_en   (pin_pull_dn_en[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Spare bits of port 2 mode A
	assign port0_schmitt_en = {P0_W{port2_mode_reg_a[P2A_SCHMITT0_BIT]}};
	assign port1_schmitt_en = {P1_W{port2_mode_reg_a[P2A_SCHMITT1_BIT]}}
		| P1_FIXED_SCHMITT;
	assign port2_schmitt_en = {P2_W{port2_mode_reg_a[P2A_SCHMITT2_BIT]}};
	assign timer_zero_toggle_en = port2_mode_reg_a[P2A_T0_TOGGLE_BIT];
	assign timer_one_toggle_en  = port2_mode_reg_a[P2A_T1_TOGGLE_BIT];
	// Clock out is only meaningful with RC or external clock, not a crystal
	assign clock_output_en = port2_mode_reg_a[P2A_CLKOUT_BIT] & ~xtal_reg;
endmodule // cio_port
`default_nettype wire

//--- verif/cio_port_monitor.sv
/* Checker of the pin driver enables of cio_port.
   Assumes a bind to cio_port; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module cio_port_monitor
	import cio_pkg::*;
(
	input wire logic			hclk,
	input wire logic			hresetn,
	input wire logic			crystal_osc_sel,
	input wire logic [cio_pkg::PIN_N-1:0]	pin_vweak_pu_en,
	input wire logic [cio_pkg::PIN_N-1:0]	pin_weak_pu_en,
	input wire logic [cio_pkg::PIN_N-1:0]	pin_strong_pu_en,
	input wire logic [cio_pkg::PIN_N-1:0]	pin_pull_dn_en,
	input wire logic [cio_pkg::PIN_N-1:0]	pin_input_en,
	input wire logic [cio_pkg::P0_W-1:0]	port0_schmitt_en,
	input wire logic [cio_pkg::P1_W-1:0]	port1_schmitt_en,
	input wire logic			clock_output_en
);
	logic [PIN_N-1:0]	qs, qs_d, nq, pu;
	logic [1:0]		up_reg;
	// Strong pulse is told from push-pull by the very weak pull-up
	assign qs = pin_strong_pu_en & pin_vweak_pu_en;
	assign nq = qs & ~qs_d;
	assign pu = pin_vweak_pu_en | pin_weak_pu_en | pin_strong_pu_en;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			qs_d <= '0;
			up_reg <= 2'h0;
		end else begin
			qs_d <= qs;
			if (up_reg != 2'h3)
				up_reg <= up_reg + 2'h1;
		end
	end
	////////////////////////////////
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rise_s; nq != '0; endsequence
	sequence hold_s; (qs & $past(nq)) == $past(nq); endsequence
	weak_vw_a: assert property ((pin_weak_pu_en & ~pin_vweak_pu_en) == '0)
		else $error("weak pull-up without latch one");
	strong_two_a: assert property (rise_s |=> hold_s)
		else $error("strong pulse too short");
	strong_max_a: assert property ((qs & $past(qs) & $past(qs, 2)) == '0)
		else $error("strong pulse too long");
	pd_pu_excl_a: assert property ((pin_pull_dn_en & pu) == '0)
		else $error("pull-up with pull-down");
	fixed_od_a: assert property ((pu & 18'h00C00) == '0)
		else $error("fixed open-drain pin pulled up");
	rst_pin_off_a: assert property (((pu | pin_pull_dn_en) & 18'h02000) == '0)
		else $error("reset input pin driven");
	xtal_off_a: assert property (
		up_reg == 2'h3 && crystal_osc_sel |->
		((pu | pin_pull_dn_en | pin_input_en) & 18'h30000) == '0 && !clock_output_en)
		else $error("oscillator pin or clock out active");
	schm_fix_a: assert property ((port1_schmitt_en & 8'h2C) == 8'h2C)
		else $error("fixed Schmitt input lost");
	schm_port_a: assert property (
		port0_schmitt_en inside {8'h00, 8'hFF} && port1_schmitt_en inside {8'h2C, 8'hFF})
		else $error("Schmitt select not per port");
endmodule // cio_port_monitor
bind cio_port cio_port_monitor u_cio_port_monitor (.hclk, .hresetn, .crystal_osc_sel,
	.pin_vweak_pu_en, .pin_weak_pu_en, .pin_strong_pu_en, .pin_pull_dn_en, .pin_input_en,
	.port0_schmitt_en, .port1_schmitt_en, .clock_output_en);
`default_nettype wire

//--- verif/cio_load.sv
/* Load model of the port pins.
   Assumes enables are high while a device is on. */
`timescale 1ns/10ps
`default_nettype none
module cio_load
	import cio_pkg::*;
(
	input wire logic			hclk,
	input wire logic [cio_pkg::PIN_N-1:0]	pu_en,
	input wire logic [cio_pkg::PIN_N-1:0]	pd_en,
	input wire logic [cio_pkg::PIN_N-1:0]	ext_low,
	output logic [cio_pkg::PIN_N-1:0]	pin
);
	logic	flt_reg;
	// A floating pin must never read as a steady level
	always_ff @(posedge hclk)
		flt_reg <= (flt_reg === 1'b1) ? 1'b0 : 1'b1;
	always_comb begin
		for (int i = 0; i < PIN_N; i++) begin
			if (pd_en[i] || ext_low[i])
				pin[i] = 1'b0;
			else if (pu_en[i])
				pin[i] = 1'b1;
			else
				pin[i] = flt_reg ^ i[0];
		end
	end
endmodule // cio_load
`default_nettype wire

//--- verif/testbench.sv
/* Bench of cio_port: bus master, enable model, load model.
   Assumes the monitor and load files are compiled with it. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import cio_pkg::*;
	logic		hclk, hresetn, hsel, hwrite, hreadyout, hresp, t0, t1, ck;
	logic		reset_level_high_sel, internal_reset_sel, crystal_osc_sel;
	logic [1:0]	htrans, sch2;
	logic [2:0]	hsize;
	logic [7:0]	sch0, sch1;
	logic [31:0]	haddr, hwdata, hrdata, r, v, w;
	logic [17:0]	vw, wk, st, pd, ie, pins, ext_low;
	logic [1:0]	md[PIN_N];
	int		lat[PIN_N], sp[PIN_N];
	int		n_errors = 0, checked = 0, cyc_n = 0;
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	cio_port u_cio_port (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .reset_level_high_sel,
		.internal_reset_sel, .crystal_osc_sel, .port0_pin_in(pins[7:0]),
		.port1_pin_in(pins[15:8]), .port2_pin_in(pins[17:16]), .pin_vweak_pu_en(vw),
		.pin_weak_pu_en(wk), .pin_strong_pu_en(st), .pin_pull_dn_en(pd), .pin_input_en(ie),
		.port0_schmitt_en(sch0), .port1_schmitt_en(sch1), .port2_schmitt_en(sch2),
		.timer_zero_toggle_en(t0), .timer_one_toggle_en(t1), .clock_output_en(ck));
	cio_load u_cio_load (.hclk, .pu_en(vw | wk | st), .pd_en(pd), .ext_low, .pin(pins));
	////////////////////////////////
	task automatic end_sim();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			n_errors++;
			end_sim();
		end
	end
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic wr_en, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr_en;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic cyc(input int n);
		repeat (n) begin
			@(posedge hclk);
			foreach (sp[i])
				if (sp[i] > 0)
					sp[i]--;
		end
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int p, j;
		bus(a, 1'b1, d);
		p = a < 8'h0C ? a / 4 : (a - 8'h0C) / 8;
		for (int i = 0; i < (p == 2 ? 2 : 8); i++) begin
			j = 8 * p + i;
			if (a < 8'h0C) begin
				if (md[j] == 2'b00 && lat[j] == 0 && d[i])
					sp[j] = 2;
				lat[j] = d[i];
			end else
				md[j][((a - 8'h0C) & 8'h4) ? 0 : 1] = d[i];
		end
	endtask
	// Weak pull-up is skipped while pin levels still cross the synchroniser
	task automatic chk(input bit wk_on);
		logic [17:0] ev, ew, es, ed;
		int m;
		bit off;
		for (int i = 0; i < PIN_N; i++) begin
			m = (i == 10 || i == 11) ? 3 : md[i];
			off = i == 13 || (i > 15 && crystal_osc_sel);
			ev[i] = !off && m == 0 && lat[i] != 0;
			ew[i] = ev[i] && !ext_low[i];
			es[i] = !off && (m == 0 ? sp[i] > 0 : m == 1 && lat[i] != 0);
			ed[i] = !off && m != 2 && lat[i] == 0;
		end
		cmp(vw, ev);
		cmp(st, es);
		cmp(pd, ed);
		if (wk_on)
			cmp(wk, ew);
	endtask
	task automatic rst(input logic hi, input logic x);
		@(posedge hclk);
		hresetn <= 1'b0;
		reset_level_high_sel <= hi;
		internal_reset_sel <= x;
		crystal_osc_sel <= x;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (lat[i]) begin
			lat[i] = hi;
			md[i] = 2'b00;
			sp[i] = 0;
		end
		cyc(5);
	endtask
	////////////////////////////////
	initial begin
		{hresetn, hsel, hwrite, htrans, haddr, hwdata, ext_low} = '0;
		hsize = 3'h2;
		{reset_level_high_sel, internal_reset_sel, crystal_osc_sel} = 3'b100;
		r = $urandom(32'h54839b31);
		rst(1'b1, 1'b0);
		chk(1'b1);
		cmp(ie[13], 1'b0);
		bus(OFS_P0_LATCH, 1'b0, 32'h0);
		cmp(r, 32'hFF);
		cmp(hresp, 1'b0);
		bus(8'h3C, 1'b0, 32'h0);
		cmp(r, 32'h0);
		$display("test reset_high done");
		rst(1'b0, 1'b0);
		chk(1'b1);
		for (int k = 0; k < 6; k++) begin
			v = k ? $urandom & 32'hFF : 32'hCC;
			w = k ? $urandom & 32'hFF : 32'hAA;
			for (int p = 0; p < 3; p++) begin
				wr(8'(OFS_P0_MODE_A + 8 * p), v);
				wr(8'(OFS_P0_MODE_B + 8 * p), w);
				wr(8'(OFS_P0_LATCH + 4 * p), $urandom & 32'hFF);
			end
			cyc(6);
			chk(1'b1);
		end
		$display("test modes done");
		wr(OFS_P0_MODE_A, 32'h0);
		wr(OFS_P0_MODE_B, 32'hF0);
		wr(OFS_P0_LATCH, 32'h0);
		cyc(6);
		wr(OFS_P0_LATCH, 32'hFF);
		for (int k = 0; k < 3; k++) begin
			cyc(k ? 1 : 0);
			chk(1'b0);
		end
		$display("test strong done");
		wr(OFS_P0_MODE_B, 32'h0);
		@(posedge hclk);
		ext_low <= 18'($urandom & 32'hFF);
		cyc(6);
		chk(1'b1);
		bus(OFS_P0_PINS, 1'b0, 32'h0);
		cmp(r, {24'h0, ~ext_low[7:0]});
		bus(OFS_P1_PINS, 1'b0, 32'h0);
		cmp(r & 32'h20, 32'h0);
		@(posedge hclk);
		ext_low <= '0;
		$display("test weak done");
		for (int k = 0; k < 4; k++) begin
			v = k < 2 ? {32{k[0]}} & 32'hFF : $urandom & 32'hFF;
			wr(OFS_P2_MODE_A, v);
			cyc(1);
			w = 32'({{2{v[7]}}, {8{v[6]}} | 8'h2C, {8{v[5]}}, v[3:2], v[4]});
			cmp(32'({sch2, sch1, sch0, t1, t0, ck}), w);
		end
		$display("test control done");
		rst(1'b1, 1'b1);
		chk(1'b1);
		cmp(ie & 18'h32000, 18'h02000);
		wr(OFS_P2_MODE_A, 32'h10);
		cyc(1);
		cmp(ck, 1'b0);
		bus(OFS_P2_PINS, 1'b0, 32'h0);
		cmp(r, 32'h0);
		$display("test crystal done");
		end_sim();
	end
endmodule // testbench
`default_nettype wire
